// ===== logic/rcm_ctrl_top.sv
// rectifier control, status and dual-port management slave
// assumes pins are asynchronous; busy, margin and level codes are on
// core_clk; the serial clock is sampled, never used as a clock
//
// Function
// - in analog or bus mode the output runs only while enable is low
// - releasing enable or hot-plug on/off switches the output off at once
// - in RS485 mode the enable input is ignored
// - trim open or above threshold gives the factory default setpoint
// - a bus voltage setting overrides the trim input until controller restart
// - after each restart the setpoint follows the trim input again
// - insertion sense above threshold enables configuration write protect
// - protocol pin pulled down selects RS485, open selects analog and bus
// - slot resistor decodes to two address bits, 30K=00 through 2.5K=11
// - eight rack levels collapse to one bit, odd levels 0, even 1
// - power capacity flag high on high line, low on low line
// - power fail warning high while output is on, low before decay
// - fault output low on fan, temperature, overvoltage or internal fault
// - status follows present state; communication errors hold until cleared, restart until read
// - a bit shows that status changed since the last host read
// - transient overvoltage trip raises alert; auto restart sets restart bit
// - a good status read clears status except communication errors
// - two ports; port 0 is connected after start-up
// - clock stretch never lasts longer than the maximum interval
// - stretch only after the acknowledge bit or at a start
// - commands without trailing error code byte are ignored
// - error code byte is CRC-8 over all message bytes
// - alert latches on change; read, clear or output recycle release it
// - both clock rates work; the lower one is the default
`timescale 1ns/1ps
module rcm_ctrl_top #(
  parameter logic [3:0] ADDR_BASE = rcm_pkg::ADDR_BASE_DEF, // arbitrary
  parameter int STRETCH_MAX_CYC = rcm_pkg::STRETCH_CYC // stretch limit
) (
  input wire logic core_clk, // 50 MHz
  input wire logic resetn, // async, active low
  input wire logic enable_n, // enable pin, low = on
  input wire logic hotplug_n, // short on/off pin, low = on
  input wire logic protocol_open, // high = open = analog/bus mode
  input wire logic trim_high, // trim open or above threshold
  input wire logic insert_high, // insertion sense above threshold
  input wire logic line_high, // high-line input detected
  input wire logic fan_fail, // fan failure
  input wire logic ot_warn, // over-temperature warning
  input wire logic ot_shut, // over-temperature shutdown
  input wire logic ov_shut, // over-voltage shutdown
  input wire logic int_fault, // internal fault
  input wire logic ov_trip, // transient over-voltage trip active
  input wire logic retry_en, // restart after trip allowed
  input wire logic decay_warn, // output about to decay
  input wire logic rs485_run, // on request from the RS485 side
  input wire logic busy, // controller busy, may stretch
  input wire logic [7:0] margin_code, // trim setpoint in volts
  input wire logic [1:0] slot_level, // slot resistor index
  input wire logic [2:0] rack_level, // rack level index, 0 = level 1
  input wire logic [1:0] scl_i, // clock pin level per port
  output logic [1:0] scl_o, // clock drive value
  output logic [1:0] scl_oe, // clock pulled low
  input wire logic [1:0] sda_i, // data pin level per port
  output logic [1:0] sda_o, // data drive value
  output logic [1:0] sda_oe, // data pulled low
  output logic main_on, // main output on
  output logic [7:0] vout_set, // setpoint in volts
  output logic eeprom_wp, // configuration write protect
  output logic rs485_mode, // RS485 mode selected
  output logic [6:0] pmbus_addr, // slave address
  output logic pwr_cap, // high-line rating
  output logic pfw, // power fail warning, low = warning
  output logic fault_n, // fault, active low
  output logic alert_n, // alert, active low
  output logic [7:0] status, // status and alarm byte
  output logic stat_changed, // changed since last read
  output logic chan_sel // connected port
);
  import rcm_pkg::*;
  typedef struct packed {
    logic [PIN_W-1:0] p1;
    logic [PIN_W-1:0] p2;
    rcm_i2c_st_t st;
    logic sel;
    logic first;
    logic rd;
    logic txn;
    logic [3:0] bitcnt;
    logic [7:0] sh;
    logic [7:0] cmd;
    logic [7:0] data;
    logic [7:0] crc;
    logic [2:0] nb;
    logic sda_dr;
    logic str_arm;
    logic str_on;
    logic [STR_W-1:0] str_cnt;
    logic [1:0] scl_o;
    logic [1:0] sda_o;
    logic [1:0] scl_oe;
    logic [1:0] sda_oe;
    logic op_on;
    logic sw_valid;
    logic [7:0] sw_vout;
    logic [7:0] vout;
    logic trip;
    logic ovt_prev;
    logic allow_q;
    logic [7:0] held;
    logic changed;
    logic alert_n;
    logic main_on;
    logic rs485;
    logic wp;
    logic pcap;
    logic pfw;
    logic fault_n;
    logic [6:0] addr;
  } rcm_core_t;
  rcm_core_t s;
  rcm_core_t n;
  // restart is an event, so it sticks like the error bits, but only until read
  localparam logic [7:0] HOLD_MASK = COMM_MASK | (8'h01 << ST_RESTART);

  logic [PIN_W-1:0] pins;
  logic [1:0] rise_v, fall_v, start_v, stop_v, sda_v;
  logic ev_start, ev_stop, ev_rise, ev_fall, ev_sda, takeover;
  logic rd_ok, clr_cmd, cmd_bad, pec_bad, allow, recyc;
  logic [2:0] nb_exp;
  logic [7:0] pec_byte, crc_nx, ev_bits, keep, new_bits;

  assign pins = {rs485_run, decay_warn, retry_en, ov_trip, int_fault,
    ov_shut, ot_shut, ot_warn, fan_fail, line_high,
    insert_high, trim_high, protocol_open, hotplug_n, enable_n};

  generate
    for (genvar i = 0; i < 2; i++) begin : g_port
      rcm_link_if lk ();
      rcm_i2c_front u_front (
        .core_clk(core_clk),
        .resetn(resetn),
        .scl_i(scl_i[i]),
        .sda_i(sda_i[i]),
        .link(lk)
      );
      assign rise_v[i] = lk.scl_rise;
      assign fall_v[i] = lk.scl_fall;
      assign start_v[i] = lk.start;
      assign stop_v[i] = lk.stop;
      assign sda_v[i] = lk.sda;
    end
  endgenerate

  // transmit bytes feed the code from the status byte
  assign pec_byte = (s.st == S_RX) ? s.sh : s.held;
  rcm_pec u_pec (
    .crc_in(s.crc),
    .byte_in(pec_byte),
    .crc_out(crc_nx)
  );

  always_comb begin
    n = s;
    rd_ok = 1'b0;
    clr_cmd = 1'b0;
    cmd_bad = 1'b0;
    pec_bad = 1'b0;
    nb_exp = (s.cmd == CMD_CLEAR_FAULTS) ? NB_NODATA : NB_DATA;
    ev_start = start_v[s.sel];
    ev_stop = stop_v[s.sel];
    ev_rise = rise_v[s.sel];
    ev_fall = fall_v[s.sel];
    ev_sda = sda_v[s.sel];
    takeover = start_v[~s.sel];
    n.p1 = pins;
    n.p2 = s.p1;
    if (s.str_on) begin
      if (!busy || s.str_cnt == STR_W'(STRETCH_MAX_CYC - 1)) begin
        n.str_on = 1'b0;
        n.str_cnt = '0;
      end else begin
        n.str_cnt = s.str_cnt + 1'b1;
      end
    end
    if (ev_fall && s.str_arm) begin
      n.str_arm = 1'b0;
      n.str_on = busy;
    end
    unique case (s.st)
      S_IDLE, S_SKIP: begin
      end
      S_RX: begin
        if (ev_rise) begin
          n.sh = {s.sh[6:0], ev_sda};
          n.bitcnt = s.bitcnt + 1'b1;
        end else if (ev_fall && s.bitcnt == BYTE_BITS) begin
          n.crc = crc_nx;
          n.nb = s.nb + 1'b1;
          n.bitcnt = '0;
          n.first = 1'b0;
          n.st = S_ACK;
          n.sda_dr = 1'b1;
          if (s.first) begin
            n.rd = s.sh[0];
            if (s.sh[7:1] != s.addr ||
                (s.sh[0] && s.cmd != CMD_READ_STATUS)) begin
              n.st = S_SKIP;
              n.sda_dr = 1'b0;
            end
          end else if (s.nb == 3'h1) begin
            n.cmd = s.sh;
          end else if (s.nb == 3'h2) begin
            n.data = s.sh;
          end
        end
      end
      S_ACK: begin
        if (ev_fall) begin
          n.sda_dr = 1'b0;
          n.str_on = busy;
          n.st = S_RX;
          if (s.rd) begin
            n.st = S_TX;
            n.sh = s.held;
            n.crc = crc_nx;
            n.sda_dr = ~s.held[7];
            n.txn = 1'b0;
          end
        end
      end
      S_TX: begin
        if (ev_rise) begin
          n.bitcnt = s.bitcnt + 1'b1;
        end else if (ev_fall) begin
          if (s.bitcnt == BYTE_BITS) begin
            n.sda_dr = 1'b0;
            n.st = S_TACK;
          end else begin
            n.sh = {s.sh[6:0], 1'b0};
            n.sda_dr = ~s.sh[6];
          end
        end
      end
      S_TACK: begin
        if (ev_rise) begin
          n.st = S_SKIP;
          rd_ok = ev_sda & s.txn;
          if (!ev_sda && !s.txn) begin
            n.st = S_LOAD;
          end
        end
      end
      S_LOAD: begin
        if (ev_fall) begin
          n.st = S_TX;
          n.bitcnt = '0;
          n.sh = s.crc;
          n.sda_dr = ~s.crc[7];
          n.txn = 1'b1;
          n.str_on = busy;
        end
      end
    endcase
    // a start on the idle port takes control, even mid transfer
    if (ev_start || takeover) begin
      n.st = S_RX;
      n.bitcnt = '0;
      n.first = 1'b1;
      n.sda_dr = 1'b0;
      n.str_arm = 1'b1;
      if (s.st == S_IDLE || takeover) begin
        n.crc = CRC_INIT;
        n.nb = '0;
        n.rd = 1'b0;
      end
      if (takeover) begin
        n.sel = ~s.sel;
        n.str_on = 1'b0;
        n.str_cnt = '0;
      end
    end else if (ev_stop) begin
      n.st = S_IDLE;
      n.sda_dr = 1'b0;
      n.str_arm = 1'b0;
      if (!s.rd && s.nb == nb_exp) begin
        if (s.crc != CRC_INIT) begin
          pec_bad = 1'b1;
        end else begin
          case (s.cmd)
            CMD_OPERATION: n.op_on = s.data[OP_ON_BIT];
            CMD_CLEAR_FAULTS: clr_cmd = 1'b1;
            CMD_VOUT: begin
              if (s.data >= VOUT_MIN && s.data <= VOUT_MAX) begin
                n.sw_vout = s.data;
                n.sw_valid = 1'b1;
              end else begin
                cmd_bad = 1'b1;
              end
            end
            default: cmd_bad = 1'b1;
          endcase
        end
      end
    end
    n.sda_oe = {n.sda_dr & n.sel, n.sda_dr & ~n.sel};
    n.scl_oe = {n.str_on & n.sel, n.str_on & ~n.sel};

    n.rs485 = ~s.p2[P_PROT_OPEN];
    allow = n.rs485 ? s.p2[P_RS_RUN]
      : (~s.p2[P_EN_N] & s.op_on);
    if (s.p2[P_OVT] && !s.p2[P_RETRY]) begin
      n.trip = 1'b1;
    end else if (!allow) begin
      n.trip = 1'b0;
    end
    n.main_on = ~s.p2[P_HP_N] & allow & ~s.p2[P_OVT] & ~s.trip
      & ~s.p2[P_OVS];
    if (s.sw_valid) begin
      n.vout = s.sw_vout;
    end else if (s.p2[P_TRIM_HI]) begin
      n.vout = VOUT_DEFAULT;
    end else begin
      n.vout = margin_code;
    end
    n.wp = s.p2[P_INSERT];
    n.pcap = s.p2[P_LINE_HI];
    n.pfw = s.main_on & ~s.p2[P_DECAY];
    n.fault_n = ~(s.p2[P_FAN] | s.p2[P_OTW] | s.p2[P_OTS]
      | s.p2[P_OVS] | s.p2[P_INT]);
    n.addr = {ADDR_BASE, rack_level[0],
      SLOT_BITS[slot_level]};
    n.ovt_prev = s.p2[P_OVT];
    n.allow_q = allow;

    ev_bits = '0;
    ev_bits[ST_FAN] = s.p2[P_FAN];
    ev_bits[ST_OTW] = s.p2[P_OTW];
    ev_bits[ST_OTS] = s.p2[P_OTS];
    ev_bits[ST_OVS] = s.p2[P_OVS] | s.p2[P_OVT];
    ev_bits[ST_INT] = s.p2[P_INT];
    ev_bits[ST_RESTART] = s.ovt_prev & ~s.p2[P_OVT] & s.p2[P_RETRY];
    ev_bits[ST_PEC] = pec_bad;
    ev_bits[ST_CMD] = cmd_bad;
    // live bits come back each cycle; error bits survive a read
    keep = s.held & HOLD_MASK & ~((rd_ok ? ~COMM_MASK : 8'h00)
      | (clr_cmd ? ALL_MASK : 8'h00));
    n.held = ev_bits | keep;
    new_bits = n.held & ~s.held;
    n.changed = (|new_bits) | (s.changed & ~rd_ok);
    recyc = allow & ~s.allow_q;
    n.alert_n = ~((|new_bits)
      | (~s.alert_n & ~(rd_ok | clr_cmd | recyc)));
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
      s.op_on <= 1'b1;
      s.vout <= VOUT_DEFAULT;
      s.alert_n <= 1'b1;
      s.fault_n <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // sampling at core_clk serves 100 kHz and 400 kHz alike
  assign scl_o = s.scl_o;
  assign scl_oe = s.scl_oe;
  assign sda_o = s.sda_o;
  assign sda_oe = s.sda_oe;
  assign main_on = s.main_on;
  assign vout_set = s.vout;
  assign eeprom_wp = s.wp;
  assign rs485_mode = s.rs485;
  assign pmbus_addr = s.addr;
  assign pwr_cap = s.pcap;
  assign pfw = s.pfw;
  assign fault_n = s.fault_n;
  assign alert_n = s.alert_n;
  assign status = s.held;
  assign stat_changed = s.changed;
  assign chan_sel = s.sel;

  logic [STR_W-1:0] hold_len;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      hold_len <= '0;
    end else begin
      hold_len <= (|s.scl_oe) ? hold_len + 1'b1 : '0;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  property p_en_release;
    (s.p2[P_EN_N] & s.p2[P_PROT_OPEN]) | s.p2[P_HP_N] |=> !main_on;
  endproperty
  a_en_release: assert property (p_en_release)
    else $error("output on after enable or on/off released");
  property p_rs485;
    !s.p2[P_PROT_OPEN] && !s.p2[P_EN_N] && !s.p2[P_RS_RUN] |=> !main_on;
  endproperty
  a_rs485: assert property (p_rs485)
    else $error("enable acted in RS485 mode");
  property p_trim;
    !s.sw_valid && s.p2[P_TRIM_HI] |=> vout_set == VOUT_DEFAULT;
  endproperty
  a_trim: assert property (p_trim)
    else $error("open trim did not give default setpoint");
  property p_sw_hold;
    s.sw_valid && !trim_high |=> ##2 vout_set == $past(s.sw_vout, 2);
  endproperty
  a_sw_hold: assert property (p_sw_hold)
    else $error("bus setpoint lost to trim input");
  property p_wp;
    s.p2[P_INSERT] |=> eeprom_wp;
  endproperty
  a_wp: assert property (p_wp)
    else $error("write protect not set");
  property p_fault;
    s.p2[P_FAN] || s.p2[P_OTS] |=> !fault_n;
  endproperty
  a_fault: assert property (p_fault)
    else $error("fault output not low");
  sequence s_new_event;
    |new_bits;
  endsequence
  sequence s_release;
    rd_ok && !(|new_bits);
  endsequence
  property p_alert_set;
    s_new_event |=> !alert_n ##1 (!alert_n || $past(rd_ok | clr_cmd | recyc));
  endproperty
  a_alert_set: assert property (p_alert_set)
    else $error("alert not latched on change");
  property p_alert_rel;
    s_release |=> alert_n && status[ST_FAN] == $past(s.p2[P_FAN]);
  endproperty
  a_alert_rel: assert property (p_alert_rel)
    else $error("status read did not release alert");
  property p_stretch_max;
    hold_len <= STR_W'(STRETCH_MAX_CYC);
  endproperty
  a_stretch_max: assert property (p_stretch_max)
    else $error("clock held low too long");
  property p_stretch_at;
    $rose(s.str_on) |-> $past(s.st == S_ACK || s.st == S_LOAD || s.str_arm);
  endproperty
  a_stretch_at: assert property (p_stretch_at)
    else $error("stretch outside ack or start");
endmodule

// ===== logic/rcm_i2c_front.sv
// one serial port front end: synchronises clock and data lines and
// reports edges, start and stop; assumes lines idle high
`timescale 1ns/1ps
module rcm_i2c_front (
  input wire logic core_clk, // core clock
  input wire logic resetn, // async reset, active low
  input wire logic scl_i, // serial clock pin level
  input wire logic sda_i, // serial data pin level
  rcm_link_if.src link // events toward the core
);
  import rcm_pkg::*;
  typedef struct packed {
    logic [1:0] m1;
    logic [1:0] m2;
    logic [1:0] q;
    logic rise;
    logic fall;
    logic start;
    logic stop;
  } rcm_front_t;
  rcm_front_t s_reg;
  rcm_front_t s_next;

  // bit 1 is the clock line, bit 0 the data line
  always_comb begin
    s_next = s_reg;
    s_next.m1 = {scl_i, sda_i};
    s_next.m2 = s_reg.m1;
    s_next.q = s_reg.m2;
    s_next.rise = s_reg.m2[1] & ~s_reg.q[1];
    s_next.fall = ~s_reg.m2[1] & s_reg.q[1];
    s_next.start = s_reg.m2[1] & s_reg.q[1] & ~s_reg.m2[0] & s_reg.q[0];
    s_next.stop = s_reg.m2[1] & s_reg.q[1] & s_reg.m2[0] & ~s_reg.q[0];
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '0;
      s_reg.m1 <= 2'h3;
      s_reg.m2 <= 2'h3;
      s_reg.q <= 2'h3;
    end else begin
      s_reg <= s_next;
    end
  end

  assign link.scl_rise = s_reg.rise;
  assign link.scl_fall = s_reg.fall;
  assign link.start = s_reg.start;
  assign link.stop = s_reg.stop;
  assign link.sda = s_reg.q[0];
endmodule

// ===== logic/rcm_link_if.sv
// serial line events from one port front end to the control core
// assumes both ends run on core_clk
`timescale 1ns/1ps
interface rcm_link_if;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic sda;
  modport src (output scl_rise, scl_fall, start, stop, sda);
  modport dst (input scl_rise, scl_fall, start, stop, sda);
endinterface

// ===== logic/rcm_pec.sv
// one byte step of the packet error code, msb first, no reflection
// assumes the caller holds the running value
`timescale 1ns/1ps
module rcm_pec (
  input wire logic [7:0] crc_in, // running value
  input wire logic [7:0] byte_in, // next message byte
  output logic [7:0] crc_out // updated value
);
  import rcm_pkg::*;
  always_comb begin
    crc_out = crc_in ^ byte_in;
    for (int i = 0; i < 8; i++) begin
      if (crc_out[7]) begin
        crc_out = {crc_out[6:0], 1'b0} ^ PEC_POLY;
      end else begin
        crc_out = {crc_out[6:0], 1'b0};
      end
    end
  end
endmodule

// ===== logic/rcm_pkg.sv
// constants, pin map, status layout and serial states of the rectifier
// control block; assumes a 50 MHz core clock
package rcm_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int STRETCH_MAX_NS = 25000000;
  // longest time: rounds down
  localparam int STRETCH_CYC = STRETCH_MAX_NS / CLK_PERIOD_NS;
  localparam int STR_W = 21;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [2:0] NB_NODATA = 3'h3;
  localparam logic [2:0] NB_DATA = 3'h4;
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [7:0] PEC_POLY = 8'h07;
  localparam logic [7:0] CMD_OPERATION = 8'h01;
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_VOUT = 8'h21;
  localparam logic [7:0] CMD_READ_STATUS = 8'h79;
  // setpoints in whole volts
  localparam logic [7:0] VOUT_DEFAULT = 8'h36;
  localparam logic [7:0] VOUT_MIN = 8'h2c;
  localparam logic [7:0] VOUT_MAX = 8'h3a;
  localparam int OP_ON_BIT = 7;
  // upper slave address bits, value arbitrary
  localparam logic [3:0] ADDR_BASE_DEF = 4'hb;
  // synchronised pin vector
  localparam int P_EN_N = 0;
  localparam int P_HP_N = 1;
  localparam int P_PROT_OPEN = 2;
  localparam int P_TRIM_HI = 3;
  localparam int P_INSERT = 4;
  localparam int P_LINE_HI = 5;
  localparam int P_FAN = 6;
  localparam int P_OTW = 7;
  localparam int P_OTS = 8;
  localparam int P_OVS = 9;
  localparam int P_INT = 10;
  localparam int P_OVT = 11;
  localparam int P_RETRY = 12;
  localparam int P_DECAY = 13;
  localparam int P_RS_RUN = 14;
  localparam int PIN_W = 15;
  // status byte
  localparam int ST_FAN = 0;
  localparam int ST_OTW = 1;
  localparam int ST_OTS = 2;
  localparam int ST_OVS = 3;
  localparam int ST_INT = 4;
  localparam int ST_RESTART = 5;
  localparam int ST_PEC = 6;
  localparam int ST_CMD = 7;
  localparam logic [7:0] COMM_MASK = 8'hc0;
  localparam logic [7:0] ALL_MASK = 8'hff;
  // slot resistor index 0..3 = 30K, 14K, 6K, 2.5K
  localparam logic [1:0] SLOT_BITS [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
  typedef enum logic [2:0] {
    S_IDLE, S_RX, S_ACK, S_TX, S_TACK, S_LOAD, S_SKIP
  } rcm_i2c_st_t;
endpackage

// ===== verification/rcm_host.sv
// host model of one serial port: a bit-banged master, 160 ns clock
// assumes the bench resolves both open-drain wires with pull-ups
`timescale 1ns/1ps
module rcm_host (
  input wire logic scl_w, // clock wire level
  input wire logic sda_w, // data wire level
  output logic scl_lo, // pulls clock low
  output logic sda_lo, // pulls data low
  output int hangs // clock waits that ran out
);
  initial begin
    scl_lo = 1'b0;
    sda_lo = 1'b0;
    hangs = 0;
  end
  task automatic bit_io(input logic b, output logic r);
    int n;
    sda_lo = !b;
    #40 scl_lo = 1'b0;
    // the slave may grab the clock a few edges after its fall
    #20 n = 0;
    while (!scl_w && n < 200) begin
      #20 n++;
    end
    if (n == 200) hangs++;
    #20 r = sda_w;
    #40 scl_lo = 1'b1;
    #40;
  endtask
  // sda goes up first, so a held ack can never look like a stop
  task automatic start();
    sda_lo = 1'b0;
    #80 scl_lo = 1'b0;
    #80 sda_lo = 1'b1;
    #80 scl_lo = 1'b1;
    #40;
  endtask
  task automatic op(input int k, input logic [7:0] b, input logic a,
                    output logic [7:0] q, output logic aq);
    logic t;
    int w;
    if (k == 0) start();
    else if (k == 1) begin
      for (int i = 7; i >= 0; i--) begin
        bit_io(b[i], t);
        q[i] = t;
      end
      bit_io(a, aq);
    end else begin
      sda_lo = 1'b1;
      #40 scl_lo = 1'b0;
      #20 w = 0;
      while (!scl_w && w < 200) begin
        #20 w++;
      end
      if (w == 200) hangs++;
      #80 sda_lo = 1'b0;
      #80;
    end
  endtask
endmodule

// ===== verification/tb.sv
// self-checking bench of the rectifier control block
// assumes two host models on pulled-up open-drain serial wires
`timescale 1ns/1ps
module tb;
  import rcm_pkg::*;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic enable_n = 1'b1, hotplug_n = 1'b1, protocol_open = 1'b1;
  logic trim_high = 1'b1, insert_high = 1'b0, line_high = 1'b0;
  logic ov_trip = 1'b0, retry_en = 1'b0, decay_warn = 1'b0;
  logic rs485_run = 1'b0, busy = 1'b0;
  logic [4:0] flt = 5'h00; // fan, otw, ots, ovs, internal
  logic [7:0] margin_code = 8'h30, ad = 8'h00, r, s, pc, vout_set, status;
  logic [1:0] slot_level = 2'h0, scl_w, sda_w, scl_oe, sda_oe, h_scl, h_sda;
  logic [2:0] rack_level = 3'h0;
  logic [6:0] pmbus_addr;
  logic a, main_on, eeprom_wp, rs485_mode, pwr_cap, pfw, fault_n, alert_n;
  logic stat_changed, chan_sel;
  int hang0, hang1;
  int fail_count = 0, samples_checked = 0;
  assign scl_w = ~(h_scl | scl_oe);
  assign sda_w = ~(h_sda | sda_oe);
  always #10 core_clk = ~core_clk;
  rcm_ctrl_top #(.STRETCH_MAX_CYC(40)) i_rcm_ctrl_top (
    .core_clk(core_clk), .resetn(resetn), .enable_n(enable_n),
    .hotplug_n(hotplug_n), .protocol_open(protocol_open),
    .trim_high(trim_high), .insert_high(insert_high), .line_high(line_high),
    .fan_fail(flt[0]), .ot_warn(flt[1]), .ot_shut(flt[2]), .ov_shut(flt[3]),
    .int_fault(flt[4]), .ov_trip(ov_trip), .retry_en(retry_en),
    .decay_warn(decay_warn), .rs485_run(rs485_run), .busy(busy),
    .margin_code(margin_code), .slot_level(slot_level),
    .rack_level(rack_level), .scl_i(scl_w), .scl_o(), .scl_oe(scl_oe),
    .sda_i(sda_w), .sda_o(), .sda_oe(sda_oe), .main_on(main_on),
    .vout_set(vout_set), .eeprom_wp(eeprom_wp), .rs485_mode(rs485_mode),
    .pmbus_addr(pmbus_addr), .pwr_cap(pwr_cap), .pfw(pfw),
    .fault_n(fault_n), .alert_n(alert_n), .status(status),
    .stat_changed(stat_changed), .chan_sel(chan_sel));
  rcm_host i_rcm_host_0 (.scl_w(scl_w[0]), .sda_w(sda_w[0]),
    .scl_lo(h_scl[0]), .sda_lo(h_sda[0]), .hangs(hang0));
  rcm_host i_rcm_host_1 (.scl_w(scl_w[1]), .sda_w(sda_w[1]),
    .scl_lo(h_scl[1]), .sda_lo(h_sda[1]), .hangs(hang1));
  task automatic step(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s exp %b got %b", nm, e, g);
    end
  endtask
  task automatic chk_byte(input string nm, input logic [7:0] e,
                          input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] x;
    x = c ^ b;
    for (int i = 0; i < 8; i++)
      x = x[7] ? {x[6:0], 1'b0} ^ PEC_POLY : {x[6:0], 1'b0};
    return x;
  endfunction
  task automatic hx(input int p, input int k, input logic [7:0] b,
                    input logic ak, output logic [7:0] q, output logic aq);
    if (p == 1)
      i_rcm_host_1.op(k, b, ak, q, aq);
    else
      i_rcm_host_0.op(k, b, ak, q, aq);
  endtask
  // n: data bytes, np: leave the code byte off, pe: corrupts the code
  task automatic wr(input int p, input logic [7:0] cmd, input logic [7:0] d,
                    input int n, input logic np, input logic [7:0] pe);
    logic [7:0] c;
    c = crc(crc(CRC_INIT, ad), cmd);
    hx(p, 0, 8'h00, 1'b1, r, a);
    hx(p, 1, ad, 1'b1, r, a);
    chk_bit("addr ack", 1'b0, a);
    hx(p, 1, cmd, 1'b1, r, a);
    if (n > 0) hx(p, 1, d, 1'b1, r, a);
    if (n > 0) c = crc(c, d);
    if (!np) hx(p, 1, c ^ pe, 1'b1, r, a);
    hx(p, 2, 8'h00, 1'b1, r, a);
    step(10);
  endtask
  initial begin
    #1ms;
    fail_count++;
    print_verdict();
  end
  initial begin
    step(6);
    resetn = 1'b1;
    step(4);
    chk_bit("chan_sel", 1'b0, chan_sel);
    chk_byte("vout_set", VOUT_DEFAULT, vout_set);
    for (int i = 0; i < 8; i++) begin
      slot_level = i[1:0];
      rack_level = ~i[2:0];
      step(2);
      chk_byte("addr", {ADDR_BASE_DEF, ~i[0], i[1:0]}, {1'b0, pmbus_addr});
    end
    ad = {ADDR_BASE_DEF, 3'h3, 1'b0};
    enable_n = 1'b0;
    hotplug_n = 1'b0;
    step(8);
    chk_bit("main_on", 1'b1, main_on);
    chk_bit("pfw", 1'b1, pfw);
    decay_warn = 1'b1;
    step(5);
    chk_bit("pfw", 1'b0, pfw);
    decay_warn = 1'b0;
    hotplug_n = 1'b1;
    step(5);
    chk_bit("main_on", 1'b0, main_on);
    hotplug_n = 1'b0;
    trim_high = 1'b0;
    step(5);
    chk_byte("vout_set", margin_code, vout_set);
    trim_high = 1'b1;
    for (int v = 1; v >= 0; v--) begin
      insert_high = v[0];
      line_high = v[0];
      step(5);
      chk_bit("eeprom_wp", v[0], eeprom_wp);
      chk_bit("pwr_cap", v[0], pwr_cap);
    end
    for (int k = 0; k < 5; k++) begin
      flt[k] = 1'b1;
      step(6);
      chk_bit("fault_n", 1'b0, fault_n);
      chk_byte("status", 8'h01 << k, status & 8'h1f);
      chk_bit("changed", 1'b1, stat_changed);
      flt[k] = 1'b0;
      step(6);
      chk_byte("status", 8'h00, status & 8'h1f);
      chk_bit("alert_n", 1'b0, alert_n);
      wr(0, CMD_CLEAR_FAULTS, 8'h00, 0, 1'b0, 8'h00);
      chk_bit("alert_n", 1'b1, alert_n);
    end
    busy = 1'b1;
    fork
      wr(0, CMD_CLEAR_FAULTS, 8'h00, 0, 1'b0, 8'h00);
      begin
        for (int n = 0; n < 3000 && scl_oe[0] !== 1'b1; n++) step(1);
        chk_bit("scl_oe", 1'b1, scl_oe[0]);
        if (scl_oe[0] !== 1'b1) print_verdict();
      end
    join
    busy = 1'b0;
    chk_bit("stretch end", 1'b1, hang0 == 0);
    protocol_open = 1'b0;
    enable_n = 1'b1;
    rs485_run = 1'b1;
    step(6);
    chk_bit("rs485_mode", 1'b1, rs485_mode);
    chk_bit("main_on", 1'b1, main_on);
    protocol_open = 1'b1;
    rs485_run = 1'b0;
    enable_n = 1'b0;
    wr(0, CMD_VOUT, VOUT_MIN, 1, 1'b0, 8'h00);
    trim_high = 1'b0;
    step(6);
    chk_byte("vout_set", VOUT_MIN, vout_set);
    trim_high = 1'b1;
    wr(0, CMD_VOUT, VOUT_MAX + 8'h01, 1, 1'b0, 8'h00);
    wr(0, CMD_CLEAR_FAULTS, 8'h00, 0, 1'b0, 8'h01);
    wr(0, CMD_VOUT, VOUT_MAX, 1, 1'b1, 8'h00);
    chk_byte("vout_set", VOUT_MIN, vout_set);
    chk_byte("status", COMM_MASK, status & COMM_MASK);
    retry_en = 1'b1;
    ov_trip = 1'b1;
    step(6);
    chk_bit("ovs", 1'b1, status[ST_OVS]);
    chk_bit("alert_n", 1'b0, alert_n);
    ov_trip = 1'b0;
    step(12);
    chk_bit("main_on", 1'b1, main_on);
    hx(0, 0, 8'h00, 1'b1, r, a);
    hx(0, 1, ad, 1'b1, r, a);
    hx(0, 1, CMD_READ_STATUS, 1'b1, r, a);
    hx(0, 0, 8'h00, 1'b1, r, a);
    hx(0, 1, ad | 8'h01, 1'b1, r, a);
    hx(0, 1, 8'hff, 1'b0, s, a);
    hx(0, 1, 8'hff, 1'b1, pc, a);
    hx(0, 2, 8'h00, 1'b1, r, a);
    step(10);
    chk_byte("read", 8'he0, s);
    chk_byte("pec", crc(crc(crc(crc(8'h00, ad), 8'h79), ad | 8'h01), s), pc);
    chk_byte("status", COMM_MASK, status);
    chk_bit("changed", 1'b0, stat_changed);
    chk_bit("alert_n", 1'b1, alert_n);
    wr(0, CMD_CLEAR_FAULTS, 8'h00, 0, 1'b0, 8'h00);
    chk_byte("status", 8'h00, status);
    hx(0, 0, 8'h00, 1'b1, r, a);
    hx(0, 1, ad, 1'b1, r, a);
    wr(1, CMD_VOUT, VOUT_MAX, 1, 1'b0, 8'h00);
    chk_bit("chan_sel", 1'b1, chan_sel);
    chk_byte("vout_set", VOUT_MAX, vout_set);
    hx(0, 2, 8'h00, 1'b1, r, a);
    chk_bit("hangs", 1'b1, hang0 + hang1 == 0);
    print_verdict();
  end
endmodule
